/* File: common/bus_grant_pkg.sv */
package bus_grant_pkg;

  // Clock and timing figures
  localparam int unsigned CORE_CLK_PERIOD_NS  = 40;
  localparam int unsigned PLL_LOCK_REF_CYCLES = 2000;
  localparam int unsigned RESET_MIN_CYCLES    = 5;
  localparam int unsigned EDGE_PULSE_MIN_NS   = 10;
  // Least time rounds up, never below one cycle
  localparam int unsigned EDGE_PULSE_RAW      =
    (EDGE_PULSE_MIN_NS + CORE_CLK_PERIOD_NS - 1) / CORE_CLK_PERIOD_NS;
  localparam int unsigned EDGE_PULSE_CYCLES   = (EDGE_PULSE_RAW < 1) ? 1 : EDGE_PULSE_RAW;

  // Widths
  localparam int unsigned LOCK_CNT_W  = 11;
  localparam int unsigned NUM_INTS    = 6;
  localparam int unsigned NUM_PFLAGS  = 8;
  localparam int unsigned NUM_FIXED   = 3;
  localparam int unsigned NUM_STROBES = 7;
  localparam int unsigned SYNC_W      = 1 + NUM_INTS + 1 + NUM_PFLAGS;

  // Positions inside the synchronised input vector
  localparam int unsigned SYNC_BR_POS   = 0;
  localparam int unsigned SYNC_INT_POS  = 1;
  localparam int unsigned SYNC_FI_POS   = 7;
  localparam int unsigned SYNC_PF_POS   = 8;

  // Interrupt slots: 0..2 edge or level, 3..4 level only, 5 edge only
  localparam int unsigned INT_EDGE_ONLY = 5;

  // Values after reset
  localparam logic [2:0]             BOOT_MODE_RST = 3'h0;
  localparam logic [NUM_PFLAGS-1:0]  PF_OE_N_RST   = 8'hff;
  localparam logic [NUM_STROBES-1:0] STROBE_RST    = 7'h7f;
  localparam logic [LOCK_CNT_W-1:0]  LOCK_TARGET   = LOCK_CNT_W'(PLL_LOCK_REF_CYCLES);

  typedef enum logic [1:0] {
    BUS_OWNED,
    BUS_FLOAT,
    BUS_GRANTED,
    BUS_RETURN
  } bus_state_t;

endpackage : bus_grant_pkg

/* File: verilog/input_sync.sv */
`timescale 1ns/1ns
module input_sync
  import bus_grant_pkg::*;
#(
  parameter int unsigned WIDTH = SYNC_W
) (
  input  wire logic             core_clk_in,
  input  wire logic             rst_in,
  input  wire logic [WIDTH-1:0] async_in,
  input  wire logic [WIDTH-1:0] rst_value_in,
  output logic      [WIDTH-1:0] sync_out
);

  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] stable;
  } sync_state_t;

  sync_state_t state_q;
  sync_state_t state_d;

  // Two stages; the first is read only by the second
  always_comb begin
    state_d        = state_q;
    state_d.meta   = async_in;
    state_d.stable = state_q.meta;
  end

  // Idle value is all ones since every synchronised pin is active low or pulled up
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      state_q <= '1;
    end else begin
      state_q <= state_d;
    end
  end

  assign sync_out = state_q.stable;

endmodule : input_sync

/* File: verilog/control_input_bus_grant.sv */
`timescale 1ns/1ns
// Functional notes
// [RULE1] Processor cycle is half the reference period
// [RULE2] Reset source waits for lock, then 5 cycles
// [RULE3] Boot mode latched from flags at reset rise
// [RULE4] Late interrupt or flag input seen next cycle
// [RULE5] Level interrupts held low until serviced
// [RULE6] Edge interrupt pulses longer than 10 ns
// [RULE7] Sample six interrupts, flag input, eight flags
// [RULE8] Flag outputs change on registered clock edge
// [RULE9] Bus request asynchronous, late means next cycle
// [RULE10] Float strobes before asserting bus grant
// [RULE11] Drive strobes only after grant is high
// [RULE12] Grant hang low with strobes already floated
// [RULE13] Release grant once request is withdrawn
// [RULE14] Asynchronous control inputs pass a synchroniser; the reset pin is used unsynchronised
module control_input_bus_grant
  import bus_grant_pkg::*;
(
  input  wire logic                   core_clk_in,
  input  wire logic                   rst_in,
  input  wire logic                   ref_clock_in,
  input  wire logic                   reset_pin_n_in,
  input  wire logic                   bus_request_n_in,
  input  wire logic                   core_needs_bus_in,
  input  wire logic [NUM_STROBES-1:0] core_strobes_n_in,
  input  wire logic [NUM_INTS-1:0]    int_pins_n_in,
  input  wire logic [2:0]             int_edge_mode_in,
  input  wire logic [NUM_INTS-1:0]    int_serviced_in,
  input  wire logic                   flag_input_in,
  input  wire logic [NUM_PFLAGS-1:0]  prog_flag_pins_in,
  input  wire logic [NUM_PFLAGS-1:0]  prog_flag_dir_out_in,
  input  wire logic [NUM_PFLAGS-1:0]  prog_flag_val_in,
  input  wire logic [NUM_FIXED-1:0]   fixed_out_val_in,
  input  wire logic                   flag_out_val_in,
  output logic                        proc_clock_out,
  output logic                        pll_locked_out,
  output logic                        core_running_out,
  output logic [2:0]                  boot_mode_out,
  output logic [NUM_INTS-1:0]         int_pending_out,
  output logic                        flag_input_out,
  output logic [NUM_PFLAGS-1:0]       prog_flag_sampled_out,
  output logic [NUM_PFLAGS-1:0]       prog_flag_pins_out,
  output logic [NUM_PFLAGS-1:0]       prog_flag_pins_oe_n_out,
  output logic [NUM_FIXED-1:0]        fixed_out_out,
  output logic                        flag_out_out,
  output logic [NUM_STROBES-1:0]      memory_select_strobes_out,
  output logic                        memory_select_strobes_oe_n_out,
  output logic                        bus_grant_n_out,
  output logic                        grant_hang_n_out
);

  typedef struct packed {
    logic                   phase;
    logic                   ref_prev;
    logic [LOCK_CNT_W-1:0]  lock_cnt;
    logic                   locked;
    logic                   rst_pin_prev;
    logic                   running;
    logic [2:0]             boot_mode;
    logic [NUM_INTS-1:0]    int_prev;
    logic [NUM_INTS-1:0]    pend;
    logic                   flag_in;
    logic [NUM_PFLAGS-1:0]  pf_in;
    logic [NUM_PFLAGS-1:0]  pf_out;
    logic [NUM_PFLAGS-1:0]  pf_oe_n;
    logic [NUM_FIXED-1:0]   fixed;
    logic                   fout;
    bus_state_t             bstate;
    logic                   grant_n;
    logic                   hang_n;
    logic                   strobe_oe_n;
    logic [NUM_STROBES-1:0] strobe;
  } ctl_state_t;

  ctl_state_t state_q;
  ctl_state_t state_d;

  logic [SYNC_W-1:0]     sync_raw;
  logic                  req_seen;
  logic [NUM_INTS-1:0]   int_sync_n;
  logic [NUM_INTS-1:0]   int_is_edge;
  logic                  ref_rise;
  logic                  rst_pin_rise;

  // Bus request, interrupt and flag inputs cross through two flops; a pin missing its window lands a cycle later
  input_sync #(
    .WIDTH(SYNC_W)
  ) u_input_sync (
    .core_clk_in  (core_clk_in),
    .rst_in       (rst_in),
    .async_in     ({prog_flag_pins_in, flag_input_in, int_pins_n_in, bus_request_n_in}), // [RULE14]
    .rst_value_in ({SYNC_W{1'b1}}),
    .sync_out     (sync_raw)
  );

  // Slices of the synchronised vector, the edge-mode map and the raw edge detects
  assign req_seen    = ~sync_raw[SYNC_BR_POS];                        // [RULE9]
  assign int_sync_n  = sync_raw[SYNC_INT_POS +: NUM_INTS];            // [RULE7]
  assign int_is_edge = {1'b1, 2'b00, int_edge_mode_in};
  assign ref_rise    = ref_clock_in & ~state_q.ref_prev;
  assign rst_pin_rise = reset_pin_n_in & ~state_q.rst_pin_prev;

  // Next-state logic for the whole front end
  always_comb begin
    state_d = state_q;
    state_d.ref_prev     = ref_clock_in;
    state_d.rst_pin_prev = reset_pin_n_in;

    // Two processor cycles per reference period, realigned at each reference rise
    state_d.phase = ref_rise ? 1'b1 : ~state_q.phase;                 // [RULE1]

    // Lock is declared only after the full reference count, so an early reset release is held
    if (!state_q.locked && ref_rise) begin
      if (state_q.lock_cnt == LOCK_TARGET - LOCK_CNT_W'(1)) begin
        state_d.locked = 1'b1;                                        // [RULE2]
      end
      state_d.lock_cnt = state_q.lock_cnt + LOCK_CNT_W'(1);
    end

    // Boot mode is caught from the raw flag pins on the reset pin's rising edge
    if (rst_pin_rise) begin
      state_d.boot_mode = prog_flag_pins_in[2:0];                     // [RULE3]
    end
    state_d.running = state_q.locked & reset_pin_n_in;

    // Interrupts: edge slots latch a falling edge, level slots follow the pin
    for (int i = 0; i < NUM_INTS; i++) begin
      if (int_is_edge[i]) begin
        state_d.pend[i] = (state_q.int_prev[i] & ~int_sync_n[i])      // [RULE4]
                        | (state_q.pend[i] & ~int_serviced_in[i]);    // set wins over service
      end else begin
        state_d.pend[i] = ~int_sync_n[i];                             // [RULE5]
      end
    end
    state_d.int_prev = int_sync_n;
    state_d.flag_in  = sync_raw[SYNC_FI_POS];                         // [RULE7]
    state_d.pf_in    = sync_raw[SYNC_PF_POS +: NUM_PFLAGS];

    // Flag outputs leave a flop so they move only at one clock edge
    state_d.pf_out  = prog_flag_val_in;                               // [RULE8]
    state_d.pf_oe_n = ~prog_flag_dir_out_in;
    state_d.fixed   = fixed_out_val_in;
    state_d.fout    = flag_out_val_in;

    // Strobe values track the core; the enable is owned by the grant machine
    state_d.strobe = core_strobes_n_in;

    // Bus grant handshake
    case (state_q.bstate)
      BUS_OWNED: begin
        if (req_seen && state_q.running) begin
          state_d.strobe_oe_n = 1'b1;                                 // [RULE10]
          state_d.bstate      = BUS_FLOAT;
        end
      end
      BUS_FLOAT: begin
        state_d.grant_n = 1'b0;                                       // [RULE10]
        state_d.bstate  = BUS_GRANTED;
      end
      BUS_GRANTED: begin
        if (!req_seen) begin
          state_d.grant_n = 1'b1;                                     // [RULE13]
          state_d.bstate  = BUS_RETURN;
        end
      end
      BUS_RETURN: begin
        state_d.strobe_oe_n = 1'b0;                                   // [RULE11]
        state_d.bstate      = BUS_OWNED;
      end
      default: begin
        state_d.bstate      = BUS_RETURN;
        state_d.grant_n     = 1'b1;
      end
    endcase

    // Hang only while granted; strobes are already floated in that state
    state_d.hang_n = ~(state_d.bstate == BUS_GRANTED && core_needs_bus_in); // [RULE12]

    // Reset pin low stops the core and clears pending interrupts; the grant machine is left as it is
    if (!reset_pin_n_in) begin
      state_d.running = 1'b0;
      state_d.pend    = '0;
    end
  end

  // State register
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      state_q <= '{
        phase: 1'b0, ref_prev: 1'b0, lock_cnt: '0, locked: 1'b0,
        rst_pin_prev: 1'b0, running: 1'b0, boot_mode: BOOT_MODE_RST,
        int_prev: '1, pend: '0, flag_in: 1'b1, pf_in: '1, pf_out: '0,
        pf_oe_n: PF_OE_N_RST, fixed: '0, fout: 1'b0, bstate: BUS_OWNED,
        grant_n: 1'b1, hang_n: 1'b1, strobe_oe_n: 1'b0, strobe: STROBE_RST
      };
    end else begin
      state_q <= state_d;
    end
  end

  // Outputs come straight from the state flops
  assign proc_clock_out                 = state_q.phase;
  assign pll_locked_out                 = state_q.locked;
  assign core_running_out               = state_q.running;
  assign boot_mode_out                  = state_q.boot_mode;
  assign int_pending_out                = state_q.pend;
  assign flag_input_out                 = state_q.flag_in;
  assign prog_flag_sampled_out          = state_q.pf_in;
  assign prog_flag_pins_out             = state_q.pf_out;
  assign prog_flag_pins_oe_n_out        = state_q.pf_oe_n;
  assign fixed_out_out                  = state_q.fixed;
  assign flag_out_out                   = state_q.fout;
  assign memory_select_strobes_out      = state_q.strobe;
  assign memory_select_strobes_oe_n_out = state_q.strobe_oe_n;
  assign bus_grant_n_out                = state_q.grant_n;
  assign grant_hang_n_out               = state_q.hang_n;

  // Grant steps as named sequences
  sequence seq_request_taken;
    req_seen && state_q.running && state_q.bstate == BUS_OWNED;
  endsequence

  sequence seq_float_then_grant;
    state_q.strobe_oe_n && state_q.grant_n ##1 state_q.strobe_oe_n && !state_q.grant_n;
  endsequence

  sequence seq_release_then_drive;
    state_q.grant_n && state_q.strobe_oe_n ##1 state_q.grant_n && !state_q.strobe_oe_n;
  endsequence

  chk_grant_after_float: assert property (@(posedge core_clk_in) disable iff (rst_in) // [RULE10]
    seq_request_taken |=> seq_float_then_grant)
    else $error("grant did not follow floated strobes");

  chk_grant_never_driven: assert property (@(posedge core_clk_in) disable iff (rst_in) // [RULE10]
    !state_q.grant_n |-> state_q.strobe_oe_n)
    else $error("strobes driven while grant low");

  chk_redrive_after_grant: assert property (@(posedge core_clk_in) disable iff (rst_in) // [RULE11]
    $fell(state_q.strobe_oe_n) |-> state_q.grant_n && $past(state_q.grant_n))
    else $error("strobes driven before grant went high");

  chk_release_on_withdraw: assert property (@(posedge core_clk_in) disable iff (rst_in) // [RULE13]
    (state_q.bstate == BUS_GRANTED && !req_seen) |=> seq_release_then_drive)
    else $error("grant not released after request withdrawn");

  chk_hang_floated: assert property (@(posedge core_clk_in) disable iff (rst_in) // [RULE12]
    !state_q.hang_n |-> state_q.strobe_oe_n && !state_q.grant_n)
    else $error("hang asserted without floated strobes");

  // Pin fall seen at N reaches req_seen at N+2, so strobes float at N+3
  chk_request_latency: assert property (@(posedge core_clk_in) disable iff (rst_in) // [RULE9]
    ($fell(bus_request_n_in) && reset_pin_n_in && state_q.running
      && state_q.bstate == BUS_OWNED) ##1 reset_pin_n_in
      |-> ##2 (state_q.strobe_oe_n || state_q.bstate != BUS_OWNED))
    else $error("request not taken within synchroniser delay");

  chk_boot_capture: assert property (@(posedge core_clk_in) disable iff (rst_in) // [RULE3]
    rst_pin_rise |=> state_q.boot_mode == $past(prog_flag_pins_in[2:0]))
    else $error("boot mode not latched at reset rise");

  chk_edge_int_latch: assert property (@(posedge core_clk_in) disable iff (rst_in) // [RULE4]
    ($fell(int_sync_n[INT_EDGE_ONLY]) && reset_pin_n_in) |=> state_q.pend[INT_EDGE_ONLY])
    else $error("edge interrupt not latched");

  chk_phase_double: assert property (@(posedge core_clk_in) disable iff (rst_in) // [RULE1]
    ref_rise |=> state_q.phase ##1 !state_q.phase)
    else $error("processor phase not aligned to reference");

  chk_lock_count: assert property (@(posedge core_clk_in) disable iff (rst_in) // [RULE2]
    $rose(state_q.locked) |-> $past(state_q.lock_cnt) == LOCK_TARGET - LOCK_CNT_W'(1))
    else $error("lock declared at wrong count");

  chk_flag_out_edge: assert property (@(posedge core_clk_in) disable iff (rst_in) // [RULE8]
    ##1 flag_out_out == $past(flag_out_val_in) && fixed_out_out == $past(fixed_out_val_in))
    else $error("flag outputs not registered");

endmodule : control_input_bus_grant

/* File: verif/ext_master_model.sv */
`timescale 1ns/1ns
// Far-side bus master and interrupt sources; every pin changes at the falling edge
module ext_master_model
  import bus_grant_pkg::*;
(
  input  wire logic                core_clk_in,
  input  wire logic                bus_grant_n_in,
  input  wire logic [NUM_INTS-1:0] int_serviced_in,
  output logic                     bus_request_n_out,
  output logic [NUM_INTS-1:0]      int_pins_n_out
);
  // Pins idle high, as with the board pull-ups
  initial begin
    bus_request_n_out = 1'b1;
    int_pins_n_out    = 6'h3f;
  end

  // Request stays low until hold cycles after grant is seen, or hold cycles after 20 cycles without grant, then drops
  task automatic use_bus(input int hold, output int waited);
    @(negedge core_clk_in);
    bus_request_n_out = 1'b0;
    waited = 0;
    while (bus_grant_n_in !== 1'b0 && waited < 20) begin
      @(negedge core_clk_in);
      waited++;
    end
    repeat (hold) @(negedge core_clk_in);
    bus_request_n_out = 1'b1;
  endtask : use_bus

  // One full cycle low, far beyond the least edge pulse width
  task automatic pulse_int(input int slot);
    @(negedge core_clk_in);
    int_pins_n_out[slot] = 1'b0;
    @(negedge core_clk_in);
    int_pins_n_out[slot] = 1'b1;
  endtask : pulse_int

  // Level source holds low until serviced; bounded so a lost service cannot hang
  task automatic level_int(input int slot);
    int n;
    n = 0;
    @(negedge core_clk_in);
    int_pins_n_out[slot] = 1'b0;
    while (int_serviced_in[slot] !== 1'b1 && n < 40) begin
      @(posedge core_clk_in);
      n++;
    end
    @(negedge core_clk_in);
    int_pins_n_out[slot] = 1'b1;
  endtask : level_int
endmodule : ext_master_model

/* File: verif/control_input_bus_grant_tb.sv */
`timescale 1ns/1ns
module control_input_bus_grant_tb;
  import bus_grant_pkg::*;
  logic                   core_clk_in = 1'b0, rst_in = 1'b1, ref_clock_in = 1'b0;
  logic                   reset_pin_n_in, bus_request_n_in, core_needs_bus_in, flag_input_in;
  logic                   flag_out_val_in, prev_grant = 1'b1;
  logic [NUM_STROBES-1:0] core_strobes_n_in;
  logic [NUM_INTS-1:0]    int_pins_n_in, int_serviced_in, int_pending_out;
  logic [2:0]             int_edge_mode_in, boot_mode_out, fixed_out_val_in, fixed_out_out;
  logic [NUM_PFLAGS-1:0]  prog_flag_pins_in, prog_flag_dir_out_in, prog_flag_val_in;
  logic [NUM_PFLAGS-1:0]  prog_flag_sampled_out, prog_flag_pins_out, prog_flag_pins_oe_n_out;
  logic [NUM_STROBES-1:0] memory_select_strobes_out;
  logic                   proc_clock_out, pll_locked_out, core_running_out, flag_input_out;
  logic                   flag_out_out, memory_select_strobes_oe_n_out, bus_grant_n_out;
  logic                   grant_hang_n_out, p;
  int                     mismatches = 0, check_count = 0, cycles = 0, rises = 0, w, n;
  int                     rise0;

  control_input_bus_grant dut (.core_clk_in(core_clk_in), .rst_in(rst_in),
    .ref_clock_in(ref_clock_in), .reset_pin_n_in(reset_pin_n_in),
    .bus_request_n_in(bus_request_n_in), .core_needs_bus_in(core_needs_bus_in),
    .core_strobes_n_in(core_strobes_n_in), .int_pins_n_in(int_pins_n_in),
    .int_edge_mode_in(int_edge_mode_in), .int_serviced_in(int_serviced_in),
    .flag_input_in(flag_input_in), .prog_flag_pins_in(prog_flag_pins_in),
    .prog_flag_dir_out_in(prog_flag_dir_out_in), .prog_flag_val_in(prog_flag_val_in),
    .fixed_out_val_in(fixed_out_val_in), .flag_out_val_in(flag_out_val_in),
    .proc_clock_out(proc_clock_out), .pll_locked_out(pll_locked_out),
    .core_running_out(core_running_out), .boot_mode_out(boot_mode_out),
    .int_pending_out(int_pending_out), .flag_input_out(flag_input_out),
    .prog_flag_sampled_out(prog_flag_sampled_out), .prog_flag_pins_out(prog_flag_pins_out),
    .prog_flag_pins_oe_n_out(prog_flag_pins_oe_n_out), .fixed_out_out(fixed_out_out),
    .flag_out_out(flag_out_out), .memory_select_strobes_out(memory_select_strobes_out),
    .memory_select_strobes_oe_n_out(memory_select_strobes_oe_n_out),
    .bus_grant_n_out(bus_grant_n_out), .grant_hang_n_out(grant_hang_n_out));

  ext_master_model m (.core_clk_in(core_clk_in), .bus_grant_n_in(bus_grant_n_out),
    .int_serviced_in(int_serviced_in), .bus_request_n_out(bus_request_n_in),
    .int_pins_n_out(int_pins_n_in));

  // Core clock, and a reference clock at half its rate so two cycles fit one period
  always #20 core_clk_in = ~core_clk_in;
  always @(negedge core_clk_in) ref_clock_in <= ~ref_clock_in;
  always @(posedge ref_clock_in) rises <= rises + 1;

  task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("Error at %0t ns: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : check

  task automatic conclude();
    if (mismatches == 0 && check_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : conclude

  // Which slots latch on an edge for a given mode setting
  function automatic logic is_edge(input logic [2:0] mode, input int s);
    return (s == INT_EDGE_ONLY) || (s < 3 && mode[s]);
  endfunction : is_edge

  // Hang: lock plus a few hundred cycles of tests fit well inside this ceiling
  always @(posedge core_clk_in) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      conclude();
    end
  end

  // Strobes stay floated throughout a grant and in the cycle grant returns high
  always @(negedge core_clk_in) if (!rst_in) begin
    if (bus_grant_n_out === 1'b0 || prev_grant === 1'b0)
      check(memory_select_strobes_oe_n_out, 1'b1, "strobes floated");
    if (bus_grant_n_out === 1'b0)
      check(grant_hang_n_out, !core_needs_bus_in, "grant hang");
    prev_grant <= bus_grant_n_out;
  end

  // Boot pins held around the reset-pin rise, reset pin low well over 5 cycles
  task automatic boot();
    logic [2:0] mode;
    mode = 3'($urandom);
    @(negedge core_clk_in);
    reset_pin_n_in = 1'b0;
    prog_flag_pins_in[2:0] = mode;
    repeat (8) @(negedge core_clk_in);
    reset_pin_n_in = 1'b1;
    repeat (2) @(negedge core_clk_in);
    check(boot_mode_out, mode, "boot mode");
    check(core_running_out, 1'b1, "running");
  endtask : boot

  initial begin
    void'($urandom(88));
    {reset_pin_n_in, core_needs_bus_in, flag_input_in, flag_out_val_in} = 4'h0;
    {core_strobes_n_in, int_serviced_in, int_edge_mode_in} = 16'hfe00;
    {prog_flag_pins_in, prog_flag_dir_out_in, prog_flag_val_in} = 24'h0;
    fixed_out_val_in = 3'h0;
    repeat (16) @(posedge core_clk_in);
    @(negedge core_clk_in);
    rst_in = 1'b0;
    rise0 = rises;
    // Request while not running is ignored
    m.use_bus(0, w);
    check(8'(w), 8'd20, "refused grant");
    // Lock must not report early, and must report within a few rises of the count
    while (rises - rise0 < PLL_LOCK_REF_CYCLES - 10) @(negedge core_clk_in);
    check(pll_locked_out, 1'b0, "early lock");
    while (rises - rise0 < PLL_LOCK_REF_CYCLES + 10) @(negedge core_clk_in);
    check(pll_locked_out, 1'b1, "lock");
    boot();
    boot();
    // Processor clock flips every core cycle
    repeat (8) begin
      p = proc_clock_out;
      @(negedge core_clk_in);
      check(proc_clock_out, !p, "proc clock");
    end
    // Random flag outputs, strobes and sampled inputs
    repeat (40) begin
      {prog_flag_dir_out_in, prog_flag_val_in, core_strobes_n_in} = 23'($urandom);
      {fixed_out_val_in, flag_out_val_in, flag_input_in} = 5'($urandom);
      prog_flag_pins_in = 8'($urandom);
      @(negedge core_clk_in);
      check(prog_flag_pins_oe_n_out, ~prog_flag_dir_out_in, "flag oe");
      check(prog_flag_pins_out, prog_flag_val_in, "flag out");
      check({fixed_out_out, flag_out_out}, {fixed_out_val_in, flag_out_val_in}, "fixed");
      check(memory_select_strobes_out, core_strobes_n_in, "strobes");
      repeat (3) @(negedge core_clk_in);
      check(prog_flag_sampled_out, prog_flag_pins_in, "pf sample");
      check(flag_input_out, flag_input_in, "flag in");
    end
    // All six interrupts, slots 0..2 in both modes
    for (int md = 0; md < 2; md++) begin
      int_edge_mode_in = md ? 3'h0 : 3'h7;
      for (int s = 0; s < NUM_INTS; s++) begin
        if (is_edge(int_edge_mode_in, s)) begin
          m.pulse_int(s);
          repeat (6) @(negedge core_clk_in);
          check(int_pending_out[s], 1'b1, "edge sticky");
        end else fork
          m.level_int(s);
          begin
            n = 0;
            while (int_pending_out[s] !== 1'b1 && n < 8) begin
              @(negedge core_clk_in);
              n++;
            end
            check(int_pending_out[s], 1'b1, "level pending");
          end
        join_any
        @(negedge core_clk_in);
        int_serviced_in[s] = 1'b1;
        @(negedge core_clk_in);
        int_serviced_in[s] = 1'b0;
        wait fork;
        repeat (5) @(negedge core_clk_in);
        check(int_pending_out[s], 1'b0, "cleared");
      end
    end
    // Bus tenures of varied length, with and without the core needing the bus
    for (int t = 0; t < 4; t++) begin
      core_needs_bus_in = t[0];
      m.use_bus(t == 0 ? 0 : 1 + ($urandom % 6), w);
      check(8'(w >= 3 && w <= 5), 8'h1, "grant latency");
      repeat (5) @(negedge core_clk_in);
      check(bus_grant_n_out, 1'b1, "grant released");
      check(grant_hang_n_out, 1'b1, "hang released");
      repeat (2) @(negedge core_clk_in);
      check(memory_select_strobes_oe_n_out, 1'b0, "strobes driven");
    end
    conclude();
  end
endmodule : control_input_bus_grant_tb
